// *** core/scm_cfg_pkg.sv ***
// constants for the supply and clock monitor configuration registers
package scm_cfg_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [7:0] SUPPLY_MONITOR_ENABLES_ADDR = 8'h41;
    localparam logic [7:0] SUPPLY_MONITOR_THRESHOLDS_ADDR = 8'h42;
    localparam logic [7:0] CLOCK_MONITOR_ENABLES_ADDR = 8'h43;
    localparam logic [15:0] SUPPLY_MONITOR_ENABLES_RST = 16'h0000;
    localparam logic [15:0] SUPPLY_MONITOR_THRESHOLDS_RST = 16'h10F0;
    localparam logic [15:0] CLOCK_MONITOR_ENABLES_RST = 16'h0000;
    // writable bits of each register
    localparam logic [15:0] SUPPLY_MONITOR_ENABLES_MASK = 16'hFFFF;
    localparam logic [15:0] SUPPLY_MONITOR_THRESHOLDS_MASK = 16'h30F0;
    localparam logic [15:0] CLOCK_MONITOR_ENABLES_RW_MASK = 16'hFC07;
    // reserved 15:10 stored but read back only through this mask
    localparam logic [15:0] CLOCK_MONITOR_ENABLES_RD_MASK = 16'hFC07;
    // enables register fields
    localparam int AN_OV_BIT = 15;
    localparam int AN_UV_BIT = 14;
    localparam int IO_OV_BIT = 13;
    localparam int IO_UV_BIT = 12;
    localparam int DG_OV_BIT = 11;
    localparam int DG_UV_BIT = 10;
    localparam int AN_OSC_BIT = 9;
    localparam int IO_OSC_BIT = 8;
    localparam int DG_OSC_BIT = 7;
    localparam int AN_OTW_BIT = 6;
    localparam int IO_OTW_BIT = 5;
    localparam int AN_CL_BIT = 4;
    localparam int IO_CL_BIT = 3;
    localparam int GA_DISC_BIT = 2;
    localparam int GB_DISC_BIT = 1;
    localparam int DIGITAL_GROUND_DISC_BIT = 0;
    // thresholds register fields
    localparam int IO_OV_TH_BIT = 13;
    localparam int IO_UV_TH_BIT = 12;
    localparam int AN_OTW_TH_LSB = 6;
    localparam int IO_OTW_TH_LSB = 4;
    // clock register fields
    localparam int MCLK_MON_BIT = 2;
    localparam int OSC_WD_BIT = 1;
    localparam int MCLK_WD_BIT = 0;
endpackage

// *** core/supply_clock_monitor_cfg_regs.sv ***
// supply and clock monitor configuration register bank
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - enables bits 15,13,11 enable analog, io, digital rail overvoltage monitors.
// - enables bits 14,12,10 enable analog, io, digital rail undervoltage monitors.
// - enables bits 9,8,7 enable analog, io, digital rail oscillation monitors.
// - enables bits 6,5 enable analog and io overtemperature warning monitors.
// - enables bits 4,3 enable analog and io regulator current limits.
// - enables bits 2,1,0 enable ground a, ground b, digital ground disconnect monitors.
// - enables register at 41h, all read/write, resets to zero.
// - thresholds register at 42h resets to 10F0h.
// - thresholds bit 13 picks io overvoltage level, zero at reset.
// - thresholds bit 12 picks io undervoltage level, one at reset.
// - thresholds bits 7:6 pick analog overtemperature level, reset 11b.
// - thresholds bits 5:4 pick io overtemperature level, reset 11b.
// - thresholds reserved bits 15:14, 11:8, 3:0 read zero, ignore writes.
// - clock register at 43h resets to zero, all monitors off.
// - clock register bits 9:3 read zero, ignore writes.
// - clock bit 2 enables the main clock frequency monitor.
// - clock bit 1 enables the diagnostic oscillator watchdog.
// - clock bit 0 enables the main clock watchdog.
module supply_clock_monitor_cfg_regs #(
    parameter int ADDR_W = scm_cfg_pkg::ADDR_W,
    parameter int DATA_W = scm_cfg_pkg::DATA_W
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    output logic reg_hit,
    input wire logic [2:0] raw_overvoltage_fault,
    input wire logic [2:0] raw_undervoltage_fault,
    input wire logic [2:0] raw_oscillation_fault,
    input wire logic [1:0] raw_overtemp_fault,
    input wire logic [2:0] raw_disconnect_fault,
    input wire logic [2:0] raw_clock_fault,
    output logic analog_rail_overvoltage_enable,
    output logic analog_rail_undervoltage_enable,
    output logic io_rail_overvoltage_enable,
    output logic io_rail_undervoltage_enable,
    output logic digital_rail_overvoltage_enable,
    output logic digital_rail_undervoltage_enable,
    output logic analog_rail_oscillation_enable,
    output logic io_rail_oscillation_enable,
    output logic digital_rail_oscillation_enable,
    output logic analog_rail_overtemp_warn_enable,
    output logic io_rail_overtemp_warn_enable,
    output logic analog_rail_current_limit_enable,
    output logic io_rail_current_limit_enable,
    output logic ground_a_disconnect_enable,
    output logic ground_b_disconnect_enable,
    output logic digital_ground_disconnect_enable,
    output logic io_rail_overvoltage_threshold,
    output logic io_rail_undervoltage_threshold,
    output logic [1:0] analog_rail_overtemp_threshold,
    output logic [1:0] io_rail_overtemp_threshold,
    output logic main_clock_freq_monitor_enable,
    output logic diag_oscillator_watchdog_enable,
    output logic main_clock_watchdog_enable,
    output logic [2:0] gated_overvoltage_fault,
    output logic [2:0] gated_undervoltage_fault,
    output logic [2:0] gated_oscillation_fault,
    output logic [1:0] gated_overtemp_fault,
    output logic [2:0] gated_disconnect_fault,
    output logic [2:0] gated_clock_fault
);

    // ************************************************************
    // fault vector layout
    // ************************************************************
    // groups packed in port order, clock faults lowest
    localparam int CLK_LSB = 0;
    localparam int DISC_LSB = CLK_LSB + $bits(raw_clock_fault);
    localparam int OTW_LSB = DISC_LSB + $bits(raw_disconnect_fault);
    localparam int OSC_LSB = OTW_LSB + $bits(raw_overtemp_fault);
    localparam int UV_LSB = OSC_LSB + $bits(raw_oscillation_fault);
    localparam int OV_LSB = UV_LSB + $bits(raw_undervoltage_fault);
    localparam int FAULT_W = OV_LSB + $bits(raw_overvoltage_fault);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        // register contents
        logic [DATA_W-1:0] sup_en;
        logic [DATA_W-1:0] sup_th;
        logic [DATA_W-1:0] clk_en;
        // access answer
        logic [DATA_W-1:0] rdata;
        logic rvalid;
        logic hit;
        // gated faults
        logic [2:0] ov_f;
        logic [2:0] uv_f;
        logic [2:0] osc_f;
        logic [1:0] otw_f;
        logic [2:0] disc_f;
        logic [2:0] clk_f;
        // three-flop synchroniser and settled level of the fault inputs
        logic [FAULT_W-1:0] raw_s1;
        logic [FAULT_W-1:0] raw_s2;
        logic [FAULT_W-1:0] raw_s3;
        logic [FAULT_W-1:0] raw_f;
    } state_t;

    // one struct holds every flop; one process registers it
    state_t st_q;
    state_t st_d;

    // ************************************************************
    // address decode
    // ************************************************************
    // decode used by both write and read paths
    function automatic logic [1:0] decode(input logic [ADDR_W-1:0] a);
        logic [1:0] sel;
        sel = 2'h0;
        if (a == ADDR_W'(scm_cfg_pkg::SUPPLY_MONITOR_ENABLES_ADDR))
        begin
            sel = 2'h1;
        end
        else if (a == ADDR_W'(scm_cfg_pkg::SUPPLY_MONITOR_THRESHOLDS_ADDR))
        begin
            sel = 2'h2;
        end
        else if (a == ADDR_W'(scm_cfg_pkg::CLOCK_MONITOR_ENABLES_ADDR))
        begin
            sel = 2'h3;
        end
        return sel;
    endfunction

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        logic [1:0] sel;
        logic [2:0] ov_en;
        logic [2:0] uv_en;
        logic [2:0] osc_en;
        logic [1:0] otw_en;
        logic [2:0] disc_en;
        logic [2:0] cm_en;
        sel = decode(reg_addr);
        ov_en = '0;
        uv_en = '0;
        osc_en = '0;
        otw_en = '0;
        disc_en = '0;
        cm_en = '0;

        // hold by default; answer pulses last one cycle
        st_d = st_q;
        st_d.rvalid = 1'b0;
        st_d.hit = 1'b0;

        // ************************************************************
        // write path, write wins over read
        // ************************************************************
        if (reg_wr)
        begin
            if (sel == 2'h1)
            begin
                st_d.sup_en = reg_wdata & scm_cfg_pkg::SUPPLY_MONITOR_ENABLES_MASK;
            end
            else if (sel == 2'h2)
            begin
                st_d.sup_th = reg_wdata & scm_cfg_pkg::SUPPLY_MONITOR_THRESHOLDS_MASK;
            end
            // reserved bits 9:3 dropped
            // bits 15:10 kept as written; the host must write zeros there
            else if (sel == 2'h3)
            begin
                st_d.clk_en = reg_wdata & scm_cfg_pkg::CLOCK_MONITOR_ENABLES_RW_MASK;
            end
            st_d.hit = (sel != 2'h0);
        end
        // ************************************************************
        // read path
        // ************************************************************
        else if (reg_rd)
        begin
            // unmapped addresses read zero
            st_d.rdata = '0;
            if (sel == 2'h1)
            begin
                st_d.rdata = st_q.sup_en;
            end
            else if (sel == 2'h2)
            begin
                st_d.rdata = st_q.sup_th & scm_cfg_pkg::SUPPLY_MONITOR_THRESHOLDS_MASK;
            end
            else if (sel == 2'h3)
            begin
                st_d.rdata = st_q.clk_en & scm_cfg_pkg::CLOCK_MONITOR_ENABLES_RD_MASK;
            end
            st_d.rvalid = 1'b1;
            st_d.hit = (sel != 2'h0);
        end

        // ************************************************************
        // enable vectors
        // ************************************************************
        // overvoltage enables
        ov_en = {st_q.sup_en[scm_cfg_pkg::AN_OV_BIT], st_q.sup_en[scm_cfg_pkg::IO_OV_BIT],
                 st_q.sup_en[scm_cfg_pkg::DG_OV_BIT]};
        uv_en = {st_q.sup_en[scm_cfg_pkg::AN_UV_BIT], st_q.sup_en[scm_cfg_pkg::IO_UV_BIT],
                 st_q.sup_en[scm_cfg_pkg::DG_UV_BIT]};
        osc_en = {st_q.sup_en[scm_cfg_pkg::AN_OSC_BIT], st_q.sup_en[scm_cfg_pkg::IO_OSC_BIT],
                  st_q.sup_en[scm_cfg_pkg::DG_OSC_BIT]};
        otw_en = {st_q.sup_en[scm_cfg_pkg::AN_OTW_BIT], st_q.sup_en[scm_cfg_pkg::IO_OTW_BIT]};
        disc_en = {st_q.sup_en[scm_cfg_pkg::GA_DISC_BIT], st_q.sup_en[scm_cfg_pkg::GB_DISC_BIT],
                   st_q.sup_en[scm_cfg_pkg::DIGITAL_GROUND_DISC_BIT]};
        cm_en = {st_q.clk_en[scm_cfg_pkg::MCLK_MON_BIT], st_q.clk_en[scm_cfg_pkg::OSC_WD_BIT],
                 st_q.clk_en[scm_cfg_pkg::MCLK_WD_BIT]};

        // ************************************************************
        // fault inputs, three synchroniser flops and a settled-level flop per bit
        // ************************************************************
        // stage one is read by stage two only
        st_d.raw_s1 = {raw_overvoltage_fault, raw_undervoltage_fault, raw_oscillation_fault,
                       raw_overtemp_fault, raw_disconnect_fault, raw_clock_fault};
        st_d.raw_s2 = st_q.raw_s1;
        st_d.raw_s3 = st_q.raw_s2;
        // a change counts once stages two and three agree
        for (int i = 0; i < FAULT_W; i++)
        begin
            // the settled level holds while they disagree
            if (st_q.raw_s2[i] == st_q.raw_s3[i])
            begin
                st_d.raw_f[i] = st_q.raw_s3[i];
            end
        end

        // ************************************************************
        // fault gating
        // ************************************************************
        // disabled monitor masks fault
        // settling adds latency, but a one-cycle glitch never reaches a gated output
        st_d.ov_f = st_q.raw_f[FAULT_W-1:OV_LSB] & ov_en;
        st_d.uv_f = st_q.raw_f[OV_LSB-1:UV_LSB] & uv_en;
        st_d.osc_f = st_q.raw_f[UV_LSB-1:OSC_LSB] & osc_en;
        st_d.otw_f = st_q.raw_f[OSC_LSB-1:OTW_LSB] & otw_en;
        st_d.disc_f = st_q.raw_f[OTW_LSB-1:DISC_LSB] & disc_en;
        st_d.clk_f = st_q.raw_f[DISC_LSB-1:CLK_LSB] & cm_en;
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            // synchroniser and gated faults start clear
            // reset values
            st_q <= '0;
            st_q.sup_en <= scm_cfg_pkg::SUPPLY_MONITOR_ENABLES_RST;
            st_q.sup_th <= scm_cfg_pkg::SUPPLY_MONITOR_THRESHOLDS_RST;
            st_q.clk_en <= scm_cfg_pkg::CLOCK_MONITOR_ENABLES_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // outputs, all straight from flops
    // ************************************************************
    // access answer
    assign reg_rdata = st_q.rdata;
    assign reg_rvalid = st_q.rvalid;
    assign reg_hit = st_q.hit;

    // ************************************************************
    // supply monitor enables
    // ************************************************************
    // one bit per monitor
    assign analog_rail_overvoltage_enable = st_q.sup_en[scm_cfg_pkg::AN_OV_BIT];
    assign analog_rail_undervoltage_enable = st_q.sup_en[scm_cfg_pkg::AN_UV_BIT];
    assign io_rail_overvoltage_enable = st_q.sup_en[scm_cfg_pkg::IO_OV_BIT];
    assign io_rail_undervoltage_enable = st_q.sup_en[scm_cfg_pkg::IO_UV_BIT];
    assign digital_rail_overvoltage_enable = st_q.sup_en[scm_cfg_pkg::DG_OV_BIT];
    assign digital_rail_undervoltage_enable = st_q.sup_en[scm_cfg_pkg::DG_UV_BIT];
    assign analog_rail_oscillation_enable = st_q.sup_en[scm_cfg_pkg::AN_OSC_BIT];
    assign io_rail_oscillation_enable = st_q.sup_en[scm_cfg_pkg::IO_OSC_BIT];
    assign digital_rail_oscillation_enable = st_q.sup_en[scm_cfg_pkg::DG_OSC_BIT];
    assign analog_rail_overtemp_warn_enable = st_q.sup_en[scm_cfg_pkg::AN_OTW_BIT];
    assign io_rail_overtemp_warn_enable = st_q.sup_en[scm_cfg_pkg::IO_OTW_BIT];
    assign analog_rail_current_limit_enable = st_q.sup_en[scm_cfg_pkg::AN_CL_BIT];
    assign io_rail_current_limit_enable = st_q.sup_en[scm_cfg_pkg::IO_CL_BIT];
    assign ground_a_disconnect_enable = st_q.sup_en[scm_cfg_pkg::GA_DISC_BIT];
    assign ground_b_disconnect_enable = st_q.sup_en[scm_cfg_pkg::GB_DISC_BIT];
    assign digital_ground_disconnect_enable = st_q.sup_en[scm_cfg_pkg::DIGITAL_GROUND_DISC_BIT];

    // ************************************************************
    // threshold selects
    // ************************************************************
    // io overvoltage level select
    assign io_rail_overvoltage_threshold = st_q.sup_th[scm_cfg_pkg::IO_OV_TH_BIT];
    assign io_rail_undervoltage_threshold = st_q.sup_th[scm_cfg_pkg::IO_UV_TH_BIT];
    assign analog_rail_overtemp_threshold = st_q.sup_th[scm_cfg_pkg::AN_OTW_TH_LSB +: 2];
    assign io_rail_overtemp_threshold = st_q.sup_th[scm_cfg_pkg::IO_OTW_TH_LSB +: 2];

    // ************************************************************
    // clock monitor enables
    // ************************************************************
    // one bit per monitor
    assign main_clock_freq_monitor_enable = st_q.clk_en[scm_cfg_pkg::MCLK_MON_BIT];
    assign diag_oscillator_watchdog_enable = st_q.clk_en[scm_cfg_pkg::OSC_WD_BIT];
    assign main_clock_watchdog_enable = st_q.clk_en[scm_cfg_pkg::MCLK_WD_BIT];

    // ************************************************************
    // gated faults
    // ************************************************************
    // settling and gating add latency; a trade for registered, glitch-free outputs
    assign gated_overvoltage_fault = st_q.ov_f;
    assign gated_undervoltage_fault = st_q.uv_f;
    assign gated_oscillation_fault = st_q.osc_f;
    assign gated_overtemp_fault = st_q.otw_f;
    assign gated_disconnect_fault = st_q.disc_f;
    assign gated_clock_fault = st_q.clk_f;

endmodule
`default_nettype wire

// *** test/scm_cfg_sva.sv ***
// checker for the supply and clock monitor configuration registers
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// access timing, field mapping and fault gating checks
// ****************************************
module scm_cfg_sva (
    input wire logic clk,
    input wire logic nrst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic reg_hit,
    input wire logic [2:0] raw_overvoltage_fault,
    input wire logic [2:0] gated_overvoltage_fault,
    input wire logic analog_rail_overvoltage_enable,
    input wire logic digital_ground_disconnect_enable,
    input wire logic [1:0] io_rail_overtemp_threshold,
    input wire logic main_clock_freq_monitor_enable
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // decoded once so each property stays short
    wire acc = reg_wr || reg_rd;
    wire mapped = (reg_addr == 8'h41) || (reg_addr == 8'h42) || (reg_addr == 8'h43);
    property p_rd; reg_rd && !reg_wr |=> reg_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read gave no valid pulse");
    property p_hit; acc && mapped |=> reg_hit; endproperty
    a_hit: assert property (p_hit) else $error("mapped access gave no hit");
    property p_miss; acc && !mapped |=> !reg_hit; endproperty
    a_miss: assert property (p_miss) else $error("unmapped access gave a hit");
    property p_an_ov; reg_wr && reg_addr == 8'h41 |=> analog_rail_overvoltage_enable == $past(reg_wdata[15]); endproperty
    a_an_ov: assert property (p_an_ov) else $error("analog overvoltage enable wrong");
    property p_digital_ground; reg_wr && reg_addr == 8'h41 |=> digital_ground_disconnect_enable == $past(reg_wdata[0]); endproperty
    a_digital_ground: assert property (p_digital_ground) else $error("ground disconnect enable wrong");
    property p_io_ot; reg_wr && reg_addr == 8'h42 |=> io_rail_overtemp_threshold == $past(reg_wdata[5:4]); endproperty
    a_io_ot: assert property (p_io_ot) else $error("io overtemp threshold wrong");
    property p_mclk; reg_wr && reg_addr == 8'h43 |=> main_clock_freq_monitor_enable == $past(reg_wdata[2]); endproperty
    a_mclk: assert property (p_mclk) else $error("clock monitor enable wrong");
    property p_rsvd; reg_rvalid && $past(reg_addr) == 8'h42 |-> (reg_rdata & 16'hCF0F) == 16'h0000; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved threshold bits not zero");
    property p_gate; gated_overvoltage_fault[2] |-> $past(analog_rail_overvoltage_enable); endproperty
    a_gate: assert property (p_gate) else $error("fault passed while disabled");
    property p_pass; $past(raw_overvoltage_fault[2], 5) && $past(raw_overvoltage_fault[2], 4) &&
        $past(analog_rail_overvoltage_enable) |-> gated_overvoltage_fault[2]; endproperty
    a_pass: assert property (p_pass) else $error("settled fault not passed while enabled");
    c_clk_wr: cover property (reg_wr && reg_addr == 8'h43);
    c_rd_data: cover property (reg_rvalid && reg_rdata != 16'h0000);
    c_fault: cover property (gated_overvoltage_fault[2]);
endmodule
`default_nettype wire

// *** test/supply_clock_monitor_cfg_regs_tb.sv ***
// self-checking bench for the supply and clock monitor configuration registers
`timescale 1ns/1ps
`default_nettype none
module supply_clock_monitor_cfg_regs_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [16:0] r = 17'h00000;
    wire [15:0] reg_rdata;
    wire reg_rvalid;
    wire reg_hit;
    wire [15:0] e;
    wire [5:0] t;
    wire [2:0] k;
    wire [16:0] g;
    int num_errors = 0;
    int comparisons = 0;
    always #2.5 clk = ~clk;
    supply_clock_monitor_cfg_regs dut_u (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .reg_hit(reg_hit), .raw_overvoltage_fault(r[16:14]), .raw_undervoltage_fault(r[13:11]),
        .raw_oscillation_fault(r[10:8]), .raw_overtemp_fault(r[7:6]), .raw_disconnect_fault(r[5:3]),
        .raw_clock_fault(r[2:0]), .analog_rail_overvoltage_enable(e[15]), .analog_rail_undervoltage_enable(e[14]),
        .io_rail_overvoltage_enable(e[13]), .io_rail_undervoltage_enable(e[12]),
        .digital_rail_overvoltage_enable(e[11]), .digital_rail_undervoltage_enable(e[10]),
        .analog_rail_oscillation_enable(e[9]), .io_rail_oscillation_enable(e[8]),
        .digital_rail_oscillation_enable(e[7]), .analog_rail_overtemp_warn_enable(e[6]),
        .io_rail_overtemp_warn_enable(e[5]), .analog_rail_current_limit_enable(e[4]),
        .io_rail_current_limit_enable(e[3]), .ground_a_disconnect_enable(e[2]),
        .ground_b_disconnect_enable(e[1]), .digital_ground_disconnect_enable(e[0]),
        .io_rail_overvoltage_threshold(t[5]), .io_rail_undervoltage_threshold(t[4]),
        .analog_rail_overtemp_threshold(t[3:2]), .io_rail_overtemp_threshold(t[1:0]),
        .main_clock_freq_monitor_enable(k[2]), .diag_oscillator_watchdog_enable(k[1]),
        .main_clock_watchdog_enable(k[0]), .gated_overvoltage_fault(g[16:14]), .gated_undervoltage_fault(g[13:11]),
        .gated_oscillation_fault(g[10:8]), .gated_overtemp_fault(g[7:6]), .gated_disconnect_fault(g[5:3]),
        .gated_clock_fault(g[2:0]));
    // ****************************************
    // access tasks, sequence and verdict
    // ****************************************
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // strobes rise and fall on falling edges, so each is sampled high at exactly one rising edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic hit);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        chk(reg_hit, hit);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input logic hit);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        chk({reg_rvalid, reg_hit, reg_rdata}, {1'b1, hit, exp});
    endtask
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        #100000;
        num_errors++;
        stop_test();
    end
    initial
    begin
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        // second pass follows a reset in mid-run with enables at AAAAh and the clock register at 0005h
        for (int p = 0; p < 2; p++)
        begin
            chk(e, 16'h0000);
            chk(t, 6'h1F);
            chk(k, 3'h0);
            rd(8'h41, 16'h0000, 1'b1);
            rd(8'h42, 16'h10F0, 1'b1);
            rd(8'h43, 16'h0000, 1'b1);
            r = 17'h1FFFF;
            // fault inputs settle through four flops before gating
            repeat (6) @(negedge clk);
            chk(g, 17'h00000);
            if (p == 0)
            begin
                for (int i = 0; i < 16; i++)
                begin
                    wr(8'h41, 16'h0001 << i, 1'b1);
                    chk(e, 16'h0001 << i);
                    rd(8'h41, 16'h0001 << i, 1'b1);
                end
                for (int c = 0; c < 4; c++)
                begin
                    wr(8'h42, {2'h3, c[1:0], 4'hF, c[1:0], ~c[1:0], 4'hF}, 1'b1);
                    chk(t, {c[1:0], c[1:0], ~c[1:0]});
                    rd(8'h42, {2'h0, c[1:0], 4'h0, c[1:0], ~c[1:0], 4'h0}, 1'b1);
                end
                for (int i = 0; i < 3; i++)
                begin
                    wr(8'h43, 16'h03F8 | (16'h0001 << i), 1'b1);
                    chk(k, 3'h1 << i);
                    rd(8'h43, 16'h0001 << i, 1'b1);
                end
                wr(8'h44, 16'hFFFF, 1'b0);
                chk(k, 3'h4);
                rd(8'h44, 16'h0000, 1'b0);
                rd(8'h40, 16'h0000, 1'b0);
                wr(8'h41, 16'hAAAA, 1'b1);
                wr(8'h43, 16'h0005, 1'b1);
                repeat (2) @(negedge clk);
                chk(g, 17'b111_000_101_01_010_101);
                r = 17'h00000;
                repeat (6) @(negedge clk);
                chk(g, 17'h00000);
                nrst = 1'b0;
                @(negedge clk);
                nrst = 1'b1;
            end
        end
        stop_test();
    end
endmodule
bind supply_clock_monitor_cfg_regs scm_cfg_sva chk_u (.*);
`default_nettype wire
